//--- hdl/eit_target.sv
`include "eit_consts.svh"

module eit_target #(
    parameter int P_PROGRAM_CYC = `EIT_INTERNAL_PROGRAM_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_chip_select_strap_low,
    input wire logic i_chip_select_strap_high,
    input wire logic i_wp,
    input wire logic [7:0] i_rd_data,
    output logic o_rd_next,
    output logic o_wr_stb,
    output logic [16:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic o_busy,
    output logic o_ready
);
    import eit_pkg::*;

    eit_link_t lq;
    eit_link_t ld;
    eit_sys_t sq;
    eit_sys_t sd;
    logic scl_f;
    logic sda_f;
    logic prog_evt;
    logic next_evt;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    // Compare a received target byte against the type pattern and straps.
    function automatic logic eit_addr_match(input logic [7:0] b, input logic [1:0] straps);
        eit_addr_match = (b[7:4] == `EIT_DEV_TYPE) && (b[3:2] == straps);
    endfunction : eit_addr_match

    // Both bus inputs are synchronised and filtered on the link clock.
    eit_pin_filter #(
        .P_STABLE(`EIT_GLITCH_REJECT_CYC)
    ) u_scl_filt (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_pin(i_scl),
        .o_level(scl_f)
    );

    eit_pin_filter #(
        .P_STABLE(`EIT_GLITCH_REJECT_CYC)
    ) u_sda_filt (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_pin(i_sda),
        .o_level(sda_f)
    );

    // Accepted write commands travel to the system clock as a toggle.
    eit_event_cross u_prog_cross (
        .i_src_clk(i_link_clk),
        .i_dst_clk(i_clk),
        .i_rst(i_rst),
        .i_pulse(lq.prog_pulse),
        .o_pulse(prog_evt)
    );

    // Requests for the following read byte cross the same way.
    eit_event_cross u_next_cross (
        .i_src_clk(i_link_clk),
        .i_dst_clk(i_clk),
        .i_rst(i_rst),
        .i_pulse(lq.next_pulse),
        .o_pulse(next_evt)
    );

    // Edge and condition decode on the filtered lines.
    assign scl_rise = scl_f && !lq.scl_q;
    assign scl_fall = !scl_f && lq.scl_q;
    assign start_c = scl_f && lq.scl_q && lq.sda_q && !sda_f;
    assign stop_c = scl_f && lq.scl_q && !lq.sda_q && sda_f;

    // Link-side protocol engine. The controller owns the clock and every START and
    // STOP, so this logic only reacts to the line and never drives the clock.
    always_comb
    begin
        ld = lq;
        ld.scl_q = scl_f;
        ld.sda_q = sda_f;
        ld.prog_pulse = 1'b0;
        ld.next_pulse = 1'b0;
        ld.sda_o = 1'b0;
        ld.busy_s1 = sq.busy;
        ld.busy_s2 = lq.busy_s1;
        ld.rdy_s1 = sq.ready;
        ld.rdy_s2 = lq.rdy_s1;
        ld.wp_s1 = i_wp;
        ld.wp_s2 = lq.wp_s1;
        ld.strap_s1 = {i_chip_select_strap_high, i_chip_select_strap_low};
        ld.strap_s2 = lq.strap_s1;
        ld.rd_s1 = i_rd_data;
        ld.rd_s2 = lq.rd_s1;
        if (stop_c)
        begin
            // A write that collected its data byte starts programming; reads and
            // aborted writes simply fall back to standby.
            if (!lq.rw && lq.have_data && !lq.wp_block)
            begin
                ld.prog_pulse = 1'b1;
            end
            ld.state = EIT_IDLE;
            ld.sda_oe = 1'b0;
            ld.have_data = 1'b0;
        end
        else if (start_c)
        begin
            // A repeated START is legal at any point and restarts reception.
            ld.state = EIT_RECV;
            ld.bit_cnt = 4'h0;
            ld.byte_idx = 2'h0;
            ld.sda_oe = 1'b0;
            ld.have_data = 1'b0;
            ld.wp_block = 1'b0;
        end
        else
        begin
            case (lq.state)
                EIT_IDLE:
                begin
                    ld.sda_oe = 1'b0;
                end
                EIT_RECV:
                begin
                    if (scl_rise && lq.bit_cnt != `EIT_BITS_PER_BYTE)
                    begin
                        ld.shift = {lq.shift[6:0], sda_f};
                        ld.bit_cnt = lq.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && lq.bit_cnt == `EIT_BITS_PER_BYTE)
                    begin
                        ld.bit_cnt = 4'h0;
                        if (lq.byte_idx == 2'h0)
                        begin
                            // Target byte: answer only when matched, idle and ready.
                            if (eit_addr_match(lq.shift, lq.strap_s2) &&
                                !lq.busy_s2 && lq.rdy_s2)
                            begin
                                ld.memory_address_msb = lq.shift[1];
                                ld.rw = lq.shift[0];
                                ld.sda_oe = 1'b1;
                                ld.state = EIT_ACK;
                            end
                            else
                            begin
                                ld.state = EIT_IDLE;
                            end
                        end
                        else if (lq.byte_idx == 2'h1)
                        begin
                            ld.addr_hi = lq.shift;
                            ld.sda_oe = 1'b1;
                            ld.state = EIT_ACK;
                        end
                        else if (lq.byte_idx == 2'h2)
                        begin
                            ld.addr_lo = lq.shift;
                            ld.sda_oe = 1'b1;
                            ld.state = EIT_ACK;
                        end
                        else if (lq.wp_block)
                        begin
                            // Protected: the data byte goes unanswered and is dropped.
                            ld.have_data = 1'b0;
                            ld.state = EIT_IDLE;
                        end
                        else
                        begin
                            // Later bytes overwrite the held one; no page buffer here.
                            ld.wdata = lq.shift;
                            ld.have_data = 1'b1;
                            ld.sda_oe = 1'b1;
                            ld.state = EIT_ACK;
                        end
                    end
                end
                EIT_ACK:
                begin
                    // The acknowledge is held through the ninth clock and dropped on
                    // its falling edge.
                    if (scl_fall)
                    begin
                        if (lq.byte_idx != `EIT_BYTE_DATA)
                        begin
                            ld.byte_idx = lq.byte_idx + 2'h1;
                        end
                        if (lq.byte_idx == 2'h2)
                        begin
                            ld.wp_block = lq.wp_s2;
                        end
                        if (lq.rw)
                        begin
                            ld.shift = lq.rd_s2;
                            ld.sda_oe = !lq.rd_s2[7];
                            ld.bit_cnt = 4'h1;
                            ld.next_pulse = 1'b1;
                            ld.state = EIT_SEND;
                        end
                        else
                        begin
                            ld.sda_oe = 1'b0;
                            ld.state = EIT_RECV;
                        end
                    end
                end
                EIT_SEND:
                begin
                    // Each falling edge presents the next bit; after eight the line
                    // is let go for the controller's answer.
                    if (scl_fall)
                    begin
                        if (lq.bit_cnt == `EIT_BITS_PER_BYTE)
                        begin
                            ld.sda_oe = 1'b0;
                            ld.mack = 1'b0;
                            ld.state = EIT_MACK;
                        end
                        else
                        begin
                            ld.shift = {lq.shift[6:0], 1'b0};
                            ld.sda_oe = !lq.shift[6];
                            ld.bit_cnt = lq.bit_cnt + 4'h1;
                        end
                    end
                end
                EIT_MACK:
                begin
                    if (scl_rise)
                    begin
                        ld.mack = !sda_f;
                    end
                    else if (scl_fall)
                    begin
                        if (lq.mack)
                        begin
                            ld.shift = lq.rd_s2;
                            ld.sda_oe = !lq.rd_s2[7];
                            ld.bit_cnt = 4'h1;
                            ld.next_pulse = 1'b1;
                            ld.state = EIT_SEND;
                        end
                        else
                        begin
                            // No acknowledge: wait released for the STOP.
                            ld.state = EIT_IDLE;
                        end
                    end
                end
                default:
                begin
                    ld.state = EIT_IDLE;
                    ld.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Supply below threshold is modelled by the reset input; every link flop takes
    // a constant there, with the line released and the bus assumed idle.
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lq <= '0;
            lq.state <= EIT_IDLE;
            lq.scl_q <= 1'b1;
            lq.sda_q <= 1'b1;
        end
        else
        begin
            lq <= ld;
        end
    end

    // System side: power-up delay, internal program interval and the memory port.
    always_comb
    begin
        sd = sq;
        sd.wr_stb = 1'b0;
        sd.rd_next = next_evt;
        if (!sq.ready)
        begin
            if (sq.por_cnt == 17'(`EIT_POWERUP_READY_CYC - 1))
            begin
                sd.ready = 1'b1;
            end
            else
            begin
                sd.por_cnt = sq.por_cnt + 17'h1;
            end
        end
        if (sq.busy)
        begin
            if (sq.busy_cnt == 17'(P_PROGRAM_CYC - 1))
            begin
                sd.busy = 1'b0;
                sd.busy_cnt = 17'h0;
            end
            else
            begin
                sd.busy_cnt = sq.busy_cnt + 17'h1;
            end
        end
        else if (prog_evt)
        begin
            // Address and data are stable in the link domain because every new
            // command is refused while busy, so they can be taken directly.
            sd.busy = 1'b1;
            sd.busy_cnt = 17'h0;
            sd.wr_stb = 1'b1;
            sd.wr_addr = {lq.memory_address_msb, lq.addr_hi, lq.addr_lo};
            sd.wr_data = lq.wdata;
        end
    end

    // Reset clears readiness, so the power-up delay restarts after every brown-out.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            sq <= '0;
        else
            sq <= sd;
    end

    // Outputs straight from flip-flops.
    assign o_sda_o = lq.sda_o;
    assign o_sda_oe = lq.sda_oe;
    assign o_rd_next = sq.rd_next;
    assign o_wr_stb = sq.wr_stb;
    assign o_wr_addr = sq.wr_addr;
    assign o_wr_data = sq.wr_data;
    assign o_busy = sq.busy;
    assign o_ready = sq.ready;

endmodule : eit_target

//--- pkg/eit_consts.svh
`ifndef EIT_CONSTS_SVH
`define EIT_CONSTS_SVH

`define EIT_DEV_TYPE 4'hA
`define EIT_SYS_CLK_NS 50
`define EIT_LINK_CLK_NS 125
`define EIT_GLITCH_REJECT_WIDTH_NS 50
`define EIT_GLITCH_RAW_CYC (`EIT_GLITCH_REJECT_WIDTH_NS / `EIT_LINK_CLK_NS)
`define EIT_GLITCH_REJECT_CYC ((`EIT_GLITCH_RAW_CYC < 1) ? 1 : `EIT_GLITCH_RAW_CYC)
`define EIT_POWERUP_READY_DELAY_NS 100000
`define EIT_POWERUP_READY_CYC (`EIT_POWERUP_READY_DELAY_NS / `EIT_SYS_CLK_NS)
`define EIT_INTERNAL_PROGRAM_TIME_NS 5000000
`define EIT_INTERNAL_PROGRAM_CYC (`EIT_INTERNAL_PROGRAM_TIME_NS / `EIT_SYS_CLK_NS)
`define EIT_CNT_W 17
`define EIT_BITS_PER_BYTE 4'h8
`define EIT_BYTE_DATA 2'h3

`endif

//--- pkg/eit_pkg.sv
package eit_pkg;

    // Link-side protocol states.
    typedef enum logic [2:0] {
        EIT_IDLE,
        EIT_RECV,
        EIT_ACK,
        EIT_SEND,
        EIT_MACK
    } eit_link_state_t;

    // Input filter state.
    typedef struct packed {
        logic s1;
        logic s2;
        logic [3:0] cnt;
        logic lvl;
    } eit_filt_t;

    // Event crossing, source half.
    typedef struct packed {
        logic tgl;
    } eit_xsrc_t;

    // Event crossing, destination half.
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic pulse;
    } eit_xdst_t;

    // Link-domain state of the target.
    typedef struct packed {
        eit_link_state_t state;
        logic scl_q;
        logic sda_q;
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic [7:0] shift;
        logic rw;
        logic memory_address_msb;
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] wdata;
        logic have_data;
        logic wp_block;
        logic sda_oe;
        logic sda_o;
        logic busy_s1;
        logic busy_s2;
        logic rdy_s1;
        logic rdy_s2;
        logic wp_s1;
        logic wp_s2;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic [7:0] rd_s1;
        logic [7:0] rd_s2;
        logic mack;
        logic prog_pulse;
        logic next_pulse;
    } eit_link_t;

    // System-domain state of the target.
    typedef struct packed {
        logic [16:0] por_cnt;
        logic ready;
        logic busy;
        logic [16:0] busy_cnt;
        logic wr_stb;
        logic [16:0] wr_addr;
        logic [7:0] wr_data;
        logic rd_next;
    } eit_sys_t;

endpackage : eit_pkg

//--- hdl/eit_pin_filter.sv
module eit_pin_filter #(
    parameter int P_STABLE = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level
);
    import eit_pkg::*;

    eit_filt_t q;
    eit_filt_t d;

    // Two flip-flops first, then a change must persist before it is accepted, so a
    // pulse caught by a single sample never becomes an edge.
    always_comb
    begin
        d = q;
        d.s1 = i_pin;
        d.s2 = q.s1;
        if (q.s2 != q.lvl)
        begin
            if (q.cnt == 4'(P_STABLE))
            begin
                d.lvl = q.s2;
                d.cnt = 4'h0;
            end
            else
            begin
                d.cnt = q.cnt + 4'h1;
            end
        end
        else
        begin
            d.cnt = 4'h0;
        end
    end

    // The idle bus is high, so the filter starts high.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            q <= '{s1: 1'b1, s2: 1'b1, cnt: 4'h0, lvl: 1'b1};
        else
            q <= d;
    end

    assign o_level = q.lvl;

endmodule : eit_pin_filter

//--- hdl/eit_event_cross.sv
module eit_event_cross (
    input wire logic i_src_clk,
    input wire logic i_dst_clk,
    input wire logic i_rst,
    input wire logic i_pulse,
    output logic o_pulse
);
    import eit_pkg::*;

    eit_xsrc_t sq;
    eit_xsrc_t sd;
    eit_xdst_t dq;
    eit_xdst_t dd;

    // A pulse becomes a toggle so that it survives any clock ratio.
    always_comb
    begin
        sd = sq;
        sd.tgl = sq.tgl ^ i_pulse;
    end

    always_ff @(posedge i_src_clk or posedge i_rst)
    begin
        if (i_rst)
            sq <= '0;
        else
            sq <= sd;
    end

    // Only the second and third stages feed the edge detector; the first stage does not.
    always_comb
    begin
        dd = dq;
        dd.s1 = sq.tgl;
        dd.s2 = dq.s1;
        dd.s3 = dq.s2;
        dd.pulse = dq.s2 ^ dq.s3;
    end

    always_ff @(posedge i_dst_clk or posedge i_rst)
    begin
        if (i_rst)
            dq <= '0;
        else
            dq <= dd;
    end

    assign o_pulse = dq.pulse;

endmodule : eit_event_cross

//--- verification/eit_ctl_model.sv
module eit_ctl_model (
    input wire logic i_link_clk,
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rel = 1'b1;
    logic glt = 1'b0;
    // The wire has a pull-up, so a released line reads high.
    assign o_sda = rel & ~i_sda_oe & ~glt;
    initial
    begin
        o_scl = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_link_clk);
    endtask : wt
    // The controller owns clock and framing; a START comes on a free bus or, without a STOP, as a repeated START.
    task automatic start();
        rel <= 1'b1;
        wt(8);
        o_scl <= 1'b1;
        wt(8);
        rel <= 1'b0;
        wt(8);
        o_scl <= 1'b0;
        wt(1);
    endtask : start
    // A STOP is followed by a free half period before anything else.
    task automatic stop();
        rel <= 1'b0;
        wt(8);
        o_scl <= 1'b1;
        wt(8);
        rel <= 1'b1;
        wt(8);
    endtask : stop
    // Data moves only while the clock is low and is read late in the high phase.
    task automatic xfer(input logic [7:0] d, input logic r9, output logic [7:0] q,
        output logic s9);
        logic [8:0] v;
        logic [8:0] w;
        v = {d, r9};
        for (int i = 8; i >= 0; i--)
        begin
            rel <= v[i];
            wt(8);
            o_scl <= 1'b1;
            wt(7);
            @(negedge i_link_clk);
            w[i] = o_sda;
            wt(1);
            o_scl <= 1'b0;
            wt(1);
        end
        q = w[8:1];
        s9 = w[0];
    endtask : xfer
    // A low pulse narrower than the reject width; it straddles exactly one sampling
    // edge, so only the input filter keeps it from being seen.
    task automatic glitch();
        @(negedge i_link_clk);
        #40 glt = 1'b1;
        #40 glt = 1'b0;
    endtask : glitch
endmodule : eit_ctl_model

//--- verification/eit_target_asserts.sv
module eit_target_asserts #(
    parameter int P_PROGRAM_CYC = 200
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic o_wr_stb,
    input wire logic o_busy,
    input wire logic o_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [16:0] busy_cnt_q;
    logic [16:0] busy_cnt_d;
    logic [11:0] up_cnt_q;
    logic [11:0] up_cnt_d;
    // Count busy cycles and the wait for ready; a stuck ready wraps harmlessly.
    always_comb
    begin
        busy_cnt_d = o_busy ? busy_cnt_q + 17'h1 : 17'h0;
        up_cnt_d = o_ready ? up_cnt_q : up_cnt_q + 12'h1;
    end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_cnt_q <= 17'h0;
            up_cnt_q <= 12'h0;
        end
        else
        begin
            busy_cnt_q <= busy_cnt_d;
            up_cnt_q <= up_cnt_d;
        end
    end
    a_sda_low_only: assert property (@(posedge i_link_clk) disable iff (i_rst)
        o_sda_oe |-> o_sda_o == 1'b0) else $error("data driven high");
    a_oe_moves_low: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $changed(o_sda_oe) |-> !i_scl && !$past(i_scl)) else $error("data moved in clock high");
    a_unready_quiet: assert property (@(posedge i_link_clk) disable iff (i_rst)
        !o_ready |-> !o_sda_oe) else $error("answer before ready");
    a_busy_no_ack: assert property (@(posedge i_link_clk) disable iff (i_rst)
        o_busy |-> !o_sda_oe) else $error("answer while busy");
    a_stb_single: assert property (@(posedge i_clk) disable iff (i_rst)
        o_wr_stb |=> !o_wr_stb) else $error("launch strobe too long");
    a_stb_then_busy: assert property (@(posedge i_clk) disable iff (i_rst)
        o_wr_stb |-> o_busy && !$past(o_busy) && o_ready ##1 o_busy [*8])
        else $error("no busy after launch");
    a_busy_length: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_busy) |-> busy_cnt_q == 17'(P_PROGRAM_CYC)) else $error("busy length wrong");
    a_ready_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_ready) |-> up_cnt_q >= 12'h5DC && up_cnt_q <= 12'h7D1) else $error("ready late");
endmodule : eit_target_asserts

bind eit_target eit_target_asserts #(.P_PROGRAM_CYC(P_PROGRAM_CYC)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_scl(i_scl),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_wr_stb(o_wr_stb), .o_busy(o_busy),
    .o_ready(o_ready));

//--- verification/eit_target_test.sv
module eit_target_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LP_PROG = 1000;
    logic clk, lclk, rst, csl, csh, wp, scl, sda, oe, sdo, rdn, stb, busy, ready;
    logic [7:0] rdd;
    logic [7:0] wdat;
    logic [16:0] wadr;
    logic [7:0] c_dat;
    logic [16:0] c_adr;
    int miscompares = 0;
    int total_checks = 0;
    int stbs = 0;
    eit_target #(.P_PROGRAM_CYC(LP_PROG)) u_dut (.i_clk(clk), .i_rst(rst), .i_link_clk(lclk),
        .i_scl(scl), .i_sda(sda), .o_sda_o(sdo), .o_sda_oe(oe),
        .i_chip_select_strap_low(csl), .i_chip_select_strap_high(csh), .i_wp(wp),
        .i_rd_data(rdd), .o_rd_next(rdn), .o_wr_stb(stb), .o_wr_addr(wadr),
        .o_wr_data(wdat), .o_busy(busy), .o_ready(ready));
    eit_ctl_model u_ctl (.i_link_clk(lclk), .i_sda_oe(oe), .o_scl(scl), .o_sda(sda));
    // The two clocks are unrelated in phase.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        lclk = 1'b0;
        #13;
        forever #62.5 lclk = ~lclk;
    end
    // Capture launches and serve the next read byte when asked.
    always @(negedge clk)
    begin
        if (stb === 1'b1)
        begin
            stbs++;
            c_adr = wadr;
            c_dat = wdat;
        end
    end
    always @(posedge clk)
    begin
        if (rdn === 1'b1)
            rdd <= 8'h3C;
    end
    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [7:0] tgt(input logic [1:0] s, input logic a, input logic r);
        return {4'hA, s, a, r};
    endfunction : tgt
    // Send one byte and compare the level seen on the ninth clock.
    task automatic sendb(input string nm, input logic [7:0] d, input logic nack);
        logic [7:0] q;
        logic b;
        u_ctl.xfer(d, 1'b1, q, b);
        chk(nm, b, nack);
    endtask : sendb
    task automatic wait_lvl(ref logic sig, input logic lvl, input int n);
        for (int k = 0; k < n && sig !== lvl; k++)
            @(negedge clk);
    endtask : wait_lvl
    task automatic t_power();
        u_ctl.start();
        sendb("early", tgt(2'h0, 1'b0, 1'b0), 1'b1);
        chk("ready_early", ready, 1'b0);
        u_ctl.stop();
        wait_lvl(ready, 1'b1, 2100);
        chk("ready", ready, 1'b1);
        $display("t_power done");
    endtask : t_power
    task automatic t_write(input logic [1:0] s, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = stbs;
        @(posedge clk);
        {csh, csl} <= s;
        u_ctl.start();
        sendb("ack_tgt", tgt(s, a[16], 1'b0), 1'b0);
        sendb("ack_hi", a[15:8], 1'b0);
        sendb("ack_lo", a[7:0], 1'b0);
        sendb("ack_dat", d, 1'b0);
        u_ctl.stop();
        for (int k = 0; k < 40 && stbs == n; k++)
            @(negedge clk);
        chk("stb", 17'(stbs - n), 17'h1);
        chk("addr", c_adr, a);
        chk("data", c_dat, d);
        u_ctl.start();
        sendb("busy_tgt", tgt(s, 1'b0, 1'b1), 1'b1);
        chk("busy", busy, 1'b1);
        u_ctl.stop();
        wait_lvl(busy, 1'b0, LP_PROG);
        chk("busy_end", busy, 1'b0);
        $display("t_write done");
    endtask : t_write
    task automatic t_refuse();
        u_ctl.start();
        sendb("bad_type", 8'hBC, 1'b1);
        u_ctl.start();
        sendb("bad_strap", tgt(2'h1, 1'b0, 1'b0), 1'b1);
        u_ctl.stop();
        u_ctl.glitch();
        sendb("no_start", tgt(2'h3, 1'b0, 1'b0), 1'b1);
        u_ctl.stop();
        // A spike in a clock-high phase would read as START and STOP and drop the frame.
        u_ctl.start();
        fork
            sendb("spike_tgt", tgt(2'h3, 1'b0, 1'b0), 1'b0);
            begin
                @(posedge scl);
                u_ctl.glitch();
            end
        join
        u_ctl.stop();
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_wp_read();
        int n;
        logic [7:0] q;
        logic b;
        n = stbs;
        @(posedge clk);
        wp <= 1'b1;
        u_ctl.start();
        sendb("wp_tgt", tgt(2'h3, 1'b0, 1'b0), 1'b0);
        sendb("wp_hi", 8'h12, 1'b0);
        sendb("wp_lo", 8'h34, 1'b0);
        sendb("wp_dat", 8'h56, 1'b1);
        u_ctl.stop();
        wp <= 1'b0;
        rdd <= 8'hA5;
        u_ctl.start();
        sendb("rd_tgt", tgt(2'h3, 1'b1, 1'b1), 1'b0);
        u_ctl.xfer(8'hFF, 1'b0, q, b);
        chk("rd_b0", q, 8'hA5);
        u_ctl.xfer(8'hFF, 1'b1, q, b);
        chk("rd_b1", q, 8'h3C);
        chk("rd_rel", b, 1'b1);
        u_ctl.stop();
        repeat (40) @(negedge clk);
        chk("no_launch", 17'(stbs - n), 17'h0);
        chk("idle", busy, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(negedge clk);
        chk("rst_ready", ready, 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        wait_lvl(ready, 1'b1, 2100);
        u_ctl.start();
        sendb("standby", tgt(2'h3, 1'b0, 1'b1), 1'b0);
        u_ctl.xfer(8'hFF, 1'b1, q, b);
        u_ctl.stop();
        $display("t_wp_read done");
    endtask : t_wp_read
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // Undriven straps and protect pin sit low, as their pull-downs would hold them.
    initial
    begin
        rst = 1'b1;
        {csh, csl, wp} = 3'h0;
        rdd = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_power();
        for (int s = 0; s < 4; s++)
            t_write(2'(s), 17'(s * 17'h8421), 8'(8'h96 + s));
        t_refuse();
        t_wp_read();
        finish_test();
    end
    // A hang past the expected run length ends the test as a failure.
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule : eit_target_test
